//--- logic/status_out_pkg.sv
// Purpose: shared constants and types for the drive status output block
// Assumes: one 100 MHz clock, synchronous active-low reset
// Notes: function codes select what each digital output line carries
package status_out_pkg;
   localparam int NUM_OUTPUTS = 4;
   localparam int FUNC_W = 8;
   localparam int POS_W = 32;
   localparam int TORQUE_W = 16;
   localparam int PCT_W = 7;
   localparam int TIME_W = 40;

   localparam logic [7:0] FUNC_IN_POSITION = 8'h05;
   localparam logic [7:0] FUNC_TORQUE_LIMIT = 8'h06;
   localparam logic [7:0] FUNC_FAULT = 8'h07;
   localparam logic [7:0] FUNC_BRAKE = 8'h08;
   localparam logic [7:0] FUNC_HOME_DONE = 8'h09;
   localparam logic [7:0] FUNC_OVERLOAD_PREWARN = 8'h10;
   localparam logic [7:0] FUNC_WARNING = 8'h11;
   localparam logic [7:0] ORIGIN_INPUT_FUNC = 8'h24;

   // overload timing is counted in milliseconds
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS = 1000000;
   localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
   localparam logic [16:0] MS_TICK_LAST = 17'(CYCLES_PER_MS - 1);
   localparam logic [6:0] PERCENT_FULL = 7'h64;
   localparam logic [7:0] ALARM_OVERLOAD = 8'h06;

   typedef enum logic [2:0] {
      MODE_EXT_PULSE_POS,
      MODE_INT_POS,
      MODE_SPEED,
      MODE_TORQUE,
      MODE_TORQUE_ZERO
   } ctrl_mode_e;

   typedef struct packed {
      logic reverse_limit;
      logic forward_limit;
      logic op_stop;
      logic serial_error;
      logic undervoltage;
      logic other_alarm;
   } alarm_cond_s;

   typedef struct packed {
      logic in_position_flag;
      logic torque_limit_flag;
      logic fault_flag;
      logic holding_brake_output;
      logic home_done_flag;
      logic overload_prewarn_flag;
      logic warning_flag;
   } status_s;
endpackage

//--- logic/overload_timer.sv
// Purpose: continuous overload time accumulation and pre-warning
// Assumes: overload_active is a level from the same clock domain
// Notes: times are in milliseconds, stepped by a one-cycle tick
`timescale 1ns/100ps
module overload_timer (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ms_tick,
   input wire logic overload_active,
   input wire logic [15:0] permit_time_ms,
   input wire logic [6:0] overload_warning_percent,
   output logic prewarn,
   output logic alarm
);
   logic [15:0] accum_ms;
   logic [15:0] next_accum_ms;
   logic prewarn_q;
   logic next_prewarn;
   logic alarm_q;
   logic next_alarm;
   logic [23:0] scaled;
   logic [23:0] prewarn_scaled;

   // compare in percent units so no divider is needed
   assign scaled = 24'(accum_ms) * 24'(status_out_pkg::PERCENT_FULL);
   assign prewarn_scaled = 24'(permit_time_ms) * 24'(overload_warning_percent);

   always_comb begin
      next_accum_ms = accum_ms;
      next_prewarn = prewarn_q;
      next_alarm = alarm_q;
      if (!overload_active) begin
         next_accum_ms = '0;
         next_prewarn = 1'b0;
      end else begin
         if (ms_tick && accum_ms != 16'hffff) begin
            next_accum_ms = accum_ms + 16'h0001;
         end
         if (scaled > prewarn_scaled) begin
            next_prewarn = 1'b1;
         end
         if (accum_ms > permit_time_ms) begin
            next_alarm = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         accum_ms <= '0;
         prewarn_q <= 1'b0;
         alarm_q <= 1'b0;
      end else begin
         accum_ms <= next_accum_ms;
         prewarn_q <= next_prewarn;
         alarm_q <= next_alarm;
      end
   end

   assign prewarn = prewarn_q;
   // the alarm is sticky until reset: clearing alarms is outside this block
   assign alarm = alarm_q;
endmodule // overload_timer

//--- logic/drive_status_output_flags.sv
// Purpose: selectable digital status outputs of a servo drive
// Assumes: all motion inputs are synchronous to clk except origin_sensor_input
// Notes: each output line carries the function chosen by its function code
//
// What this block does
// - pulse position mode: in position when error within window
// - internal position: in position within target band
// - torque-limit flag, not in torque modes
// - fault flag on other_alarm or overload alarm, all modes
// - limit, stop, serial, undervoltage raise warning first
// - brake output follows brake timing settings
// - homing done when origin sensor seen during homing, internal position only
// - home flag low after power-up, then held
// - position overflow clears home flag
// - new homing command clears home flag immediately
// - prewarn when overload time exceeds scaled permit
// - prewarn selectable by code, internal position only
// - overload beyond permit raises alarm and fault
// - warning flag code selectable, all modes
`timescale 1ns/100ps
module drive_status_output_flags (
   input wire logic clk,
   input wire logic reset_n,
   input wire status_out_pkg::ctrl_mode_e ctrl_mode,
   input wire logic [4*8-1:0] func_codes,
   input wire logic [31:0] position_error,
   input wire logic [31:0] motor_position,
   input wire logic [31:0] target_position,
   input wire logic [15:0] in_position_window,
   input wire logic [15:0] motor_torque,
   input wire logic [15:0] torque_limit,
   input wire status_out_pkg::alarm_cond_s alarm_cond,
   input wire logic brake_request,
   input wire logic [15:0] brake_on_delay_setting,
   input wire logic [15:0] brake_off_delay_setting,
   input wire logic homing_start,
   input wire logic homing_active,
   input wire logic origin_sensor_input,
   input wire logic position_overflow,
   input wire logic overload_active,
   input wire logic [15:0] permit_time_ms,
   input wire logic [6:0] overload_warning_percent,
   output logic [3:0] dout,
   output status_out_pkg::status_s status,
   output logic [7:0] alarm_code
);
   // ----------------------------------------------------------------
   // millisecond tick and origin sensor synchroniser
   // ----------------------------------------------------------------
   logic [16:0] tick_cnt;
   logic [16:0] next_tick_cnt;
   logic ms_tick;
   logic origin_meta;
   logic origin_sync;

   always_comb begin
      next_tick_cnt = tick_cnt + 17'h00001;
      if (tick_cnt == status_out_pkg::MS_TICK_LAST) begin
         next_tick_cnt = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tick_cnt <= '0;
         origin_meta <= 1'b0;
         origin_sync <= 1'b0;
      end else begin
         tick_cnt <= next_tick_cnt;
         origin_meta <= origin_sensor_input;
         origin_sync <= origin_meta;
      end
   end

   assign ms_tick = (tick_cnt == status_out_pkg::MS_TICK_LAST);

   // ----------------------------------------------------------------
   // overload timing
   // ----------------------------------------------------------------
   logic ol_prewarn;
   logic ol_alarm;

   overload_timer u_overload (
      .clk(clk),
      .reset_n(reset_n),
      .ms_tick(ms_tick),
      .overload_active(overload_active),
      .permit_time_ms(permit_time_ms),
      .overload_warning_percent(overload_warning_percent),
      .prewarn(ol_prewarn),
      .alarm(ol_alarm)
   );

   // ----------------------------------------------------------------
   // position and torque conditions
   // ----------------------------------------------------------------
   logic pulse_mode;
   logic int_mode;
   logic [31:0] abs_err;
   logic [31:0] diff;
   logic [31:0] abs_diff;
   logic in_pos;
   logic tq_lim;
   logic warn_cond;
   logic fault_cond;

   assign pulse_mode = (ctrl_mode == status_out_pkg::MODE_EXT_PULSE_POS);
   assign int_mode = (ctrl_mode == status_out_pkg::MODE_INT_POS);
   assign abs_err = position_error[31] ? 32'(-position_error) : position_error;
   assign diff = motor_position - target_position;
   assign abs_diff = diff[31] ? 32'(-diff) : diff;

   always_comb begin
      in_pos = 1'b0;
      if (pulse_mode) begin
         in_pos = (abs_err <= 32'(in_position_window));
      end else if (int_mode) begin
         in_pos = (abs_diff <= 32'(in_position_window));
      end
   end

   // torque modes leave the flag inactive
   assign tq_lim = (motor_torque >= torque_limit) &&
      (ctrl_mode != status_out_pkg::MODE_TORQUE) &&
      (ctrl_mode != status_out_pkg::MODE_TORQUE_ZERO);

   assign warn_cond = alarm_cond.reverse_limit | alarm_cond.forward_limit |
      alarm_cond.op_stop | alarm_cond.serial_error | alarm_cond.undervoltage;
   // warning sources go to the warning flag, not straight to fault
   assign fault_cond = alarm_cond.other_alarm | ol_alarm;

   // ----------------------------------------------------------------
   // holding brake timing
   // ----------------------------------------------------------------
   logic brake_q;
   logic next_brake_q;
   logic [15:0] brake_cnt;
   logic [15:0] next_brake_cnt;

   always_comb begin
      next_brake_q = brake_q;
      next_brake_cnt = brake_cnt;
      if (brake_request == brake_q) begin
         next_brake_cnt = '0;
      end else if (ms_tick) begin
         next_brake_cnt = brake_cnt + 16'h0001;
         if (brake_request && brake_cnt >= brake_on_delay_setting) begin
            next_brake_q = 1'b1;
            next_brake_cnt = '0;
         end else if (!brake_request && brake_cnt >= brake_off_delay_setting) begin
            next_brake_q = 1'b0;
            next_brake_cnt = '0;
         end
      end
   end

   // ----------------------------------------------------------------
   // homing completed
   // ----------------------------------------------------------------
   logic home_q;
   logic next_home_q;

   always_comb begin
      next_home_q = home_q;
      if (homing_active && origin_sync) begin
         next_home_q = 1'b1;
      end
      // a restart or overflow outranks completion in the same cycle
      if (homing_start || position_overflow) begin
         next_home_q = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // output selection
   // ----------------------------------------------------------------
   status_out_pkg::status_s next_status;
   logic [3:0] next_dout;
   logic [7:0] next_alarm_code;

   always_comb begin
      next_status.in_position_flag = in_pos;
      next_status.torque_limit_flag = tq_lim;
      next_status.fault_flag = fault_cond;
      next_status.holding_brake_output = brake_q;
      next_status.home_done_flag = home_q & int_mode;
      next_status.overload_prewarn_flag = ol_prewarn & int_mode;
      next_status.warning_flag = warn_cond;
      next_alarm_code = ol_alarm ? status_out_pkg::ALARM_OVERLOAD : 8'h00;
      for (int i = 0; i < status_out_pkg::NUM_OUTPUTS; i++) begin
         case (func_codes[i*8 +: 8])
            status_out_pkg::FUNC_IN_POSITION: next_dout[i] = next_status.in_position_flag;
            status_out_pkg::FUNC_TORQUE_LIMIT: next_dout[i] = next_status.torque_limit_flag;
            status_out_pkg::FUNC_FAULT: next_dout[i] = next_status.fault_flag;
            status_out_pkg::FUNC_BRAKE: next_dout[i] = next_status.holding_brake_output;
            status_out_pkg::FUNC_HOME_DONE: next_dout[i] = next_status.home_done_flag;
            status_out_pkg::FUNC_OVERLOAD_PREWARN: begin
               next_dout[i] = next_status.overload_prewarn_flag;
            end
            status_out_pkg::FUNC_WARNING: next_dout[i] = next_status.warning_flag;
            default: next_dout[i] = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         brake_q <= 1'b0;
         brake_cnt <= '0;
         home_q <= 1'b0;
         status <= '0;
         dout <= '0;
         alarm_code <= '0;
      end else begin
         brake_q <= next_brake_q;
         brake_cnt <= next_brake_cnt;
         home_q <= next_home_q;
         status <= next_status;
         dout <= next_dout;
         alarm_code <= next_alarm_code;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_pulse_inpos;
      @(posedge clk) disable iff (!reset_n)
      pulse_mode && abs_err <= 32'(in_position_window) |=> status.in_position_flag;
   endproperty
   a_pulse_inpos: assert property (p_pulse_inpos) else $error("in position missed");

   property p_int_inpos;
      @(posedge clk) disable iff (!reset_n)
      int_mode && abs_diff > 32'(in_position_window) |=> !status.in_position_flag;
   endproperty
   a_int_inpos: assert property (p_int_inpos) else $error("in position outside band");

   property p_torque_mode;
      @(posedge clk) disable iff (!reset_n)
      ctrl_mode == status_out_pkg::MODE_TORQUE_ZERO |=> !status.torque_limit_flag;
   endproperty
   a_torque_mode: assert property (p_torque_mode) else $error("torque flag in torque mode");

   property p_fault;
      @(posedge clk) disable iff (!reset_n)
      alarm_cond.other_alarm |=> status.fault_flag;
   endproperty
   a_fault: assert property (p_fault) else $error("fault flag missed");

   property p_warn_first;
      @(posedge clk) disable iff (!reset_n)
      warn_cond && !alarm_cond.other_alarm && !ol_alarm |=>
         status.warning_flag && !status.fault_flag;
   endproperty
   a_warn_first: assert property (p_warn_first) else $error("warning not first");

   sequence s_home_restart;
      homing_start;
   endsequence
   property p_home_clear;
      @(posedge clk) disable iff (!reset_n)
      s_home_restart |=> !home_q ##1 !status.home_done_flag;
   endproperty
   a_home_clear: assert property (p_home_clear) else $error("home flag not cleared");

   property p_overflow;
      @(posedge clk) disable iff (!reset_n)
      position_overflow |=> !home_q;
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow kept home flag");

   property p_home_set;
      @(posedge clk) disable iff (!reset_n)
      homing_active && origin_sync && !homing_start && !position_overflow |=> home_q;
   endproperty
   a_home_set: assert property (p_home_set) else $error("home flag not set");

   property p_prewarn_mode;
      @(posedge clk) disable iff (!reset_n)
      !int_mode |=> !status.overload_prewarn_flag;
   endproperty
   a_prewarn_mode: assert property (p_prewarn_mode) else $error("prewarn outside mode");

   property p_overload_end;
      @(posedge clk) disable iff (!reset_n)
      !overload_active |=> !ol_prewarn ##1 !status.overload_prewarn_flag;
   endproperty
   a_overload_end: assert property (p_overload_end) else $error("prewarn after overload");

   property p_overload_fault;
      @(posedge clk) disable iff (!reset_n)
      ol_alarm |=> status.fault_flag && alarm_code == status_out_pkg::ALARM_OVERLOAD;
   endproperty
   a_overload_fault: assert property (p_overload_fault) else $error("no overload fault");

   property p_warn_flag;
      @(posedge clk) disable iff (!reset_n)
      warn_cond |=> status.warning_flag;
   endproperty
   a_warn_flag: assert property (p_warn_flag) else $error("warning flag missed");

   // the brake may only move on a millisecond tick, so delays are whole ms
   property p_brake_tick;
      @(posedge clk) disable iff (!reset_n)
      !ms_tick |=> $stable(brake_q);
   endproperty
   a_brake_tick: assert property (p_brake_tick) else $error("brake moved off tick");
endmodule // drive_status_output_flags

//--- dv/status_reader.sv
// Purpose: model of the external controller that reads the drive output lines
// Assumes: lines are sampled on the drive clock
// Notes: a real controller sees the lines one register later, so the bench judges that view
`timescale 1ns/100ps
module status_reader (
   input wire logic clk,
   input wire logic [3:0] dout,
   output logic [3:0] seen
);
   always_ff @(posedge clk) begin
      seen <= dout;
   end
endmodule // status_reader

//--- dv/drive_status_output_flags_tb_top.sv
// Purpose: self-checking bench for the drive status output block
// Assumes: line codes 0x05, 0x07, 0x09, 0x10 on lines 0..3
// Notes: the overload case waits one full millisecond tick, the long part of the run
`timescale 1ns/100ps
module drive_status_output_flags_tb_top;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   status_out_pkg::ctrl_mode_e ctrl_mode = status_out_pkg::MODE_EXT_PULSE_POS;
   logic [31:0] func_codes = {8'h10, 8'h09, 8'h07, 8'h05};
   logic [31:0] position_error = 32'h0, motor_position = 32'h0, target_position = 32'h0;
   logic [15:0] in_position_window = 16'h000a, motor_torque = 16'h0, torque_limit = 16'h0100;
   status_out_pkg::alarm_cond_s alarm_cond = '0;
   logic brake_request = 1'b0, homing_start = 1'b0, homing_active = 1'b0;
   logic origin_sensor_input = 1'b0, position_overflow = 1'b0, overload_active = 1'b0;
   logic [15:0] brake_on_delay_setting = 16'h0, brake_off_delay_setting = 16'h0;
   logic [15:0] permit_time_ms = 16'h0001;
   logic [6:0] overload_warning_percent = 7'h32;
   logic [3:0] dout, seen;
   status_out_pkg::status_s status;
   logic [7:0] alarm_code;
   int fail_count = 0;
   int n_tests = 0;

   always #5 clk = ~clk;

   drive_status_output_flags uut (.clk(clk), .reset_n(reset_n), .ctrl_mode(ctrl_mode),
      .func_codes(func_codes), .position_error(position_error),
      .motor_position(motor_position), .target_position(target_position),
      .in_position_window(in_position_window), .motor_torque(motor_torque),
      .torque_limit(torque_limit), .alarm_cond(alarm_cond), .brake_request(brake_request),
      .brake_on_delay_setting(brake_on_delay_setting),
      .brake_off_delay_setting(brake_off_delay_setting), .homing_start(homing_start),
      .homing_active(homing_active), .origin_sensor_input(origin_sensor_input),
      .position_overflow(position_overflow), .overload_active(overload_active),
      .permit_time_ms(permit_time_ms), .overload_warning_percent(overload_warning_percent),
      .dout(dout), .status(status), .alarm_code(alarm_code));

   status_reader reader (.clk(clk), .dout(dout), .seen(seen));

   // ------------------------------------------------------------
   // shared helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask

   // several edges so both the registered status and the reader view have landed
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic test_in_position();
      position_error = 32'h0000000a;
      settle(3);
      chk(seen[0], 1'b1);
      position_error = 32'h0000000b;
      settle(3);
      chk(seen[0], 1'b0);
      ctrl_mode = status_out_pkg::MODE_INT_POS;
      target_position = 32'h00000064;
      motor_position = 32'h0000005a;
      settle(3);
      chk(seen[0], 1'b1);
      motor_position = 32'h00000059;
      settle(3);
      chk(seen[0], 1'b0);
      motor_position = 32'h0000006e;
      settle(3);
      chk(seen[0], 1'b1);
      ctrl_mode = status_out_pkg::MODE_SPEED;
      settle(3);
      chk(seen[0], 1'b0);
   endtask

   task automatic test_torque();
      motor_torque = 16'h0100;
      settle(3);
      chk(status.torque_limit_flag, 1'b1);
      motor_torque = 16'h00ff;
      settle(3);
      chk(status.torque_limit_flag, 1'b0);
      motor_torque = 16'h0100;
      ctrl_mode = status_out_pkg::MODE_TORQUE;
      settle(3);
      chk(status.torque_limit_flag, 1'b0);
      ctrl_mode = status_out_pkg::MODE_TORQUE_ZERO;
      settle(3);
      chk(status.torque_limit_flag, 1'b0);
   endtask

   task automatic test_alarms();
      alarm_cond = 6'h01;
      settle(3);
      chk(seen[1], 1'b1);
      chk(status.warning_flag, 1'b0);
      for (int i = 1; i < 6; i++) begin
         alarm_cond = 6'(1 << i);
         settle(3);
         chk(status.warning_flag, 1'b1);
         chk(seen[1], 1'b0);
      end
      alarm_cond = '0;
      settle(3);
      chk(status.warning_flag, 1'b0);
   endtask

   task automatic test_codes();
      ctrl_mode = status_out_pkg::MODE_SPEED;
      motor_torque = 16'h0100;
      alarm_cond = 6'h20;
      func_codes = {8'h11, 8'h08, 8'h06, 8'h00};
      settle(3);
      chk(seen[0], 1'b0);
      chk(seen[1], 1'b1);
      chk(seen[2], 1'b0);
      chk(seen[3], 1'b1);
      alarm_cond = '0;
      ctrl_mode = status_out_pkg::MODE_TORQUE;
      settle(3);
      chk(seen[1], 1'b0);
      chk(seen[3], 1'b0);
      func_codes = {8'h10, 8'h09, 8'h07, 8'h05};
   endtask

   task automatic home_once();
      homing_active = 1'b1;
      origin_sensor_input = 1'b1;
      settle(6);
      homing_active = 1'b0;
      origin_sensor_input = 1'b0;
      settle(3);
   endtask

   task automatic test_homing();
      ctrl_mode = status_out_pkg::MODE_INT_POS;
      settle(3);
      chk(status.home_done_flag, 1'b0);
      home_once();
      chk(seen[2], 1'b1);
      chk(status.home_done_flag, 1'b1);
      ctrl_mode = status_out_pkg::MODE_EXT_PULSE_POS;
      settle(3);
      chk(seen[2], 1'b0);
      ctrl_mode = status_out_pkg::MODE_INT_POS;
      homing_start = 1'b1;
      settle(1);
      homing_start = 1'b0;
      settle(2);
      chk(status.home_done_flag, 1'b0);
      home_once();
      chk(status.home_done_flag, 1'b1);
      position_overflow = 1'b1;
      settle(1);
      position_overflow = 1'b0;
      settle(5);
      chk(status.home_done_flag, 1'b0);
   endtask

   task automatic test_overload();
      int n;
      brake_request = 1'b1;
      overload_active = 1'b1;
      n = 0;
      while (status.overload_prewarn_flag !== 1'b1 && n < 101000) begin
         settle(1);
         n++;
      end
      settle(3);
      chk(status.overload_prewarn_flag, 1'b1);
      chk(seen[3], 1'b1);
      chk(status.holding_brake_output, 1'b1);
      chk(alarm_code, 8'h00);
      chk(status.fault_flag, 1'b0);
      // a zero permit makes the held one-ms count exceed it without a second tick
      func_codes[23:16] = 8'h08;
      permit_time_ms = 16'h0000;
      settle(3);
      chk(seen[2], 1'b1);
      chk(alarm_code, status_out_pkg::ALARM_OVERLOAD);
      chk(seen[1], 1'b1);
      overload_active = 1'b0;
      settle(3);
      chk(status.overload_prewarn_flag, 1'b0);
      chk(seen[3], 1'b0);
      chk(seen[1], 1'b1);
   endtask

   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      settle(3);
      chk(status, '0);
      reset_n = 1'b1;
      settle(1);
      test_in_position();
      test_torque();
      test_alarms();
      test_codes();
      test_homing();
      test_overload();
      give_verdict();
   end

   // the overload wait is about one millisecond, so allow a margin past it
   initial begin
      #1300000;
      fail_count++;
      give_verdict();
   end
endmodule // drive_status_output_flags_tb_top
